// ### rtl/sro_pkg.sv
`default_nettype none

package sro_pkg;

    // ----------------------------------------------------------------
    // character geometry
    // ----------------------------------------------------------------
    localparam int unsigned CHAR_MAX = 8;
    localparam int unsigned HOLD_W = 9;
    localparam int unsigned PARITY_POS = 8;
    localparam logic [3:0] CHAR_LEN_MIN = 4'h5;
    localparam logic [3:0] CHAR_LEN_MAX = 4'h8;
    localparam logic [7:0] FULL_MASK = 8'hFF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [8:0] HOLD_RESET = 9'h1FF;
    localparam logic [7:0] MATCH_RESET = 8'h00;
    localparam logic [1:0] LEN_SEL_RESET = 2'h3;
    localparam logic PARITY_OFF_RESET = 1'b1;
    localparam logic EVEN_SEL_RESET = 1'b0;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned PIN_W = 3;
    localparam int unsigned PIN_CLK = 2;
    localparam int unsigned PIN_DATA = 1;
    localparam int unsigned PIN_HUNT = 0;

    // ----------------------------------------------------------------
    // receiver framing states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HUNT = 3'b010,
        ST_SYNC = 3'b100
    } sro_state_type;

endpackage

`default_nettype wire

// ### rtl/sro_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module sro_pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned STAGES = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // asynchronous pins and their synchronised copies
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    // ----------------------------------------------------------------
    // one flip-flop chain per pin
    // ----------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("sro_pin_sync needs at least two stages");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [STAGES-1:0] chain_q;
        // only the last stage is read outside the chain
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                chain_q <= '0;
            end else begin
                chain_q <= {chain_q[STAGES-2:0], pin_in[i]};
            end
        end
        assign pin_sync[i] = chain_q[STAGES-1];
    end

endmodule

`default_nettype wire

// ### rtl/sro_receiver.sv
// Functional notes
// - short characters come out right-justified, unused upper bits low.
// - character in parallel on holding outputs, parity bit on ninth line.
// - holding outputs driven only while chip_disable is low.
// - parity_off high checks none; else even_parity_select picks even/odd.
// - host presents parity settings and pulses load; device captures them.
// - parity checked on the bit after the last data bit.
// - low error_flags_clear resets parity error and overrun flags.
// - low received_flag_clear resets the data-received flag.
// - data-received rises when a character enters the holding register.
// - first sync found raises match flag but not data-received.
// - transfer and data-received update at middle of final bit.
// - settings and clear inputs ignored while chip_disable is high.
// - overrun set when new character lands while data-received still set.
// - sync hunt rise starts search; fall drops sync, holding transparent.
// - match flag raised at last bit when character equals match value.
// - master clear idles, holding all ones, clears match and flags.
`timescale 1ns/100ps
`default_nettype none

module sro_receiver (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // serial link pins
    input wire logic rx_clk_pin,
    input wire logic rx_data_pin,
    input wire logic sync_hunt_input,
    // host control
    input wire logic master_clear,
    input wire logic chip_disable,
    input wire logic parity_off,
    input wire logic even_parity_select,
    input wire logic [1:0] char_len_select,
    input wire logic control_load,
    input wire logic [7:0] match_char_in,
    input wire logic match_load,
    input wire logic error_flags_clear_n,
    input wire logic received_flag_clear_n,
    // holding register outputs
    output logic [8:0] rx_holding_data,
    output logic rx_holding_data_oe,
    // status flags
    output logic char_received_flag,
    output logic parity_error_flag,
    output logic overrun_flag,
    output logic match_flag
);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [sro_pkg::PIN_W-1:0] pins_raw;
    logic [sro_pkg::PIN_W-1:0] pins_s;
    logic link_clk_s;
    logic link_data_s;
    logic hunt_s;
    logic link_clk_prev_q;
    logic hunt_prev_q;
    logic bit_strobe;
    logic hunt_rise;
    logic hunt_fall;

    assign pins_raw = {rx_clk_pin, rx_data_pin, sync_hunt_input};

    sro_pin_sync #(
        .WIDTH(sro_pkg::PIN_W),
        .STAGES(sro_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(pins_raw),
        .pin_sync(pins_s)
    );

    assign link_clk_s = pins_s[sro_pkg::PIN_CLK];
    assign link_data_s = pins_s[sro_pkg::PIN_DATA];
    assign hunt_s = pins_s[sro_pkg::PIN_HUNT];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_clk_prev_q <= 1'b0;
            hunt_prev_q <= 1'b0;
        end else begin
            link_clk_prev_q <= link_clk_s;
            hunt_prev_q <= hunt_s;
        end
    end

    // the falling link clock edge sits in the middle of each bit
    assign bit_strobe = link_clk_prev_q & ~link_clk_s;
    assign hunt_rise = ~hunt_prev_q & hunt_s;
    assign hunt_fall = hunt_prev_q & ~hunt_s;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic parity_off_q;
    logic even_sel_q;
    logic [1:0] len_sel_q;
    logic host_enabled;

    assign host_enabled = ~chip_disable;

    // gated control load
    // master clear leaves these alone on purpose
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            parity_off_q <= sro_pkg::PARITY_OFF_RESET;
            even_sel_q <= sro_pkg::EVEN_SEL_RESET;
            len_sel_q <= sro_pkg::LEN_SEL_RESET;
        end else if (control_load && host_enabled) begin
            parity_off_q <= parity_off;
            even_sel_q <= even_parity_select;
            len_sel_q <= char_len_select;
        end
    end

    // ----------------------------------------------------------------
    // character length helpers
    // ----------------------------------------------------------------
    logic [3:0] char_len;
    logic [3:0] char_last;
    logic [3:0] justify_amt;
    logic [7:0] len_mask;
    logic par_en;

    assign char_len = sro_pkg::CHAR_LEN_MIN + {2'b00, len_sel_q};
    assign char_last = char_len - 4'h1;
    assign justify_amt = sro_pkg::CHAR_LEN_MAX - char_len;
    assign len_mask = sro_pkg::FULL_MASK >> justify_amt;
    assign par_en = ~parity_off_q;

    // ----------------------------------------------------------------
    // match register
    // ----------------------------------------------------------------
    logic [7:0] match_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            match_q <= sro_pkg::MATCH_RESET;
        end else if (master_clear) begin
            match_q <= sro_pkg::MATCH_RESET;
        end else if (match_load && host_enabled) begin
            match_q <= match_char_in & len_mask;
        end
    end

    // ----------------------------------------------------------------
    // framing state
    // ----------------------------------------------------------------
    sro_pkg::sro_state_type state_q;
    logic [3:0] cnt_q;
    logic skip_q;
    logic [7:0] shift_q;
    logic [7:0] shift_nx;
    logic [7:0] char_nx;
    logic [7:0] char_done;
    logic [7:0] xfer_data;
    logic par_slot;
    logic last_bit;
    logic hunt_hit;
    logic xfer_ev;
    logic xfer_match;
    logic xfer_parity;
    logic par_err;

    assign shift_nx = {link_data_s, shift_q[7:1]};
    assign char_nx = shift_nx >> justify_amt;
    assign char_done = shift_q >> justify_amt;

    // parity slot after the data bits
    assign par_slot = par_en && (cnt_q == char_len);
    assign last_bit = par_en ? (cnt_q == char_len) : (cnt_q == char_last);

    assign hunt_hit = (state_q == sro_pkg::ST_HUNT) && bit_strobe
        && (char_nx == (match_q & len_mask));
    // transfer at middle of final bit
    assign xfer_ev = (state_q == sro_pkg::ST_SYNC) && bit_strobe
        && !skip_q && last_bit;
    assign xfer_data = par_slot ? char_done : char_nx;
    assign xfer_parity = par_slot ? link_data_s : 1'b0;
    assign xfer_match = (xfer_data == (match_q & len_mask));
    assign par_err = (^{xfer_data, link_data_s}) ^ ~even_sel_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= sro_pkg::ST_IDLE;
        end else if (master_clear || hunt_fall) begin
            state_q <= sro_pkg::ST_IDLE;
        end else if (hunt_rise) begin
            state_q <= sro_pkg::ST_HUNT;
        end else begin
            case (state_q)
                sro_pkg::ST_IDLE: begin
                    state_q <= sro_pkg::ST_IDLE;
                end
                sro_pkg::ST_HUNT: begin
                    if (hunt_hit) begin
                        state_q <= sro_pkg::ST_SYNC;
                    end
                end
                sro_pkg::ST_SYNC: begin
                    state_q <= sro_pkg::ST_SYNC;
                end
                default: begin
                    state_q <= sro_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sync character's own parity bit is skipped, not transferred
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            skip_q <= 1'b0;
        end else if (master_clear || state_q != sro_pkg::ST_SYNC) begin
            cnt_q <= 4'h0;
            skip_q <= hunt_hit && par_en;
        end else if (bit_strobe) begin
            if (skip_q) begin
                skip_q <= 1'b0;
            end else if (last_bit) begin
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // data bits shift lsb first; parity bit stays out of the shifter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_q <= sro_pkg::MATCH_RESET;
        end else if (master_clear) begin
            shift_q <= sro_pkg::MATCH_RESET;
        end else if (bit_strobe && !par_slot && !skip_q) begin
            shift_q <= shift_nx;
        end
    end

    // ----------------------------------------------------------------
    // holding register
    // ----------------------------------------------------------------
    // holding set to all ones on reset and master clear, else loaded from the shifter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_holding_data <= sro_pkg::HOLD_RESET;
        end else if (master_clear) begin
            rx_holding_data <= sro_pkg::HOLD_RESET;
        end else if (state_q != sro_pkg::ST_SYNC && bit_strobe) begin
            rx_holding_data <= {1'b0, char_nx};
        end else if (xfer_ev) begin
            rx_holding_data <= {xfer_parity, xfer_data};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_holding_data_oe <= 1'b0;
        end else begin
            rx_holding_data_oe <= host_enabled;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    logic clr_err;
    logic clr_dr;

    assign clr_err = ~error_flags_clear_n & host_enabled;
    assign clr_dr = ~received_flag_clear_n & host_enabled;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            char_received_flag <= 1'b0;
        end else if (master_clear || clr_dr) begin
            char_received_flag <= 1'b0;
        end else if (xfer_ev) begin
            char_received_flag <= 1'b1;
        end
    end

    // overrun flag
    // the lost character is simply overwritten in the holding register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrun_flag <= 1'b0;
        end else if (master_clear || clr_err) begin
            overrun_flag <= 1'b0;
        end else if (xfer_ev && char_received_flag) begin
            overrun_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            parity_error_flag <= 1'b0;
        end else if (master_clear || clr_err) begin
            parity_error_flag <= 1'b0;
        end else if (xfer_ev && par_en && par_err) begin
            parity_error_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            match_flag <= 1'b0;
        end else if (master_clear) begin
            match_flag <= 1'b0;
        end else if (hunt_hit) begin
            match_flag <= 1'b1;
        end else if (xfer_ev) begin
            match_flag <= xfer_match;
        end
    end

endmodule

`default_nettype wire

// ### verification/sro_receiver_properties.sv
`timescale 1ns/100ps
`default_nettype none

module sro_receiver_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host control
    input wire logic master_clear,
    input wire logic chip_disable,
    input wire logic [1:0] char_len_select,
    input wire logic control_load,
    input wire logic error_flags_clear_n,
    input wire logic received_flag_clear_n,
    // holding outputs and flags
    input wire logic [8:0] rx_holding_data,
    input wire logic rx_holding_data_oe,
    input wire logic char_received_flag,
    input wire logic parity_error_flag,
    input wire logic overrun_flag,
    input wire logic match_flag
);
    // ----------------------------------------------------------------
    // length shadow
    // ----------------------------------------------------------------
    logic [1:0] len_q;
    // master_clear leaves it alone, as it does the control register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            len_q <= 2'h3;
        end else if (control_load && !chip_disable) begin
            len_q <= char_len_select;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rx_clear;
        !received_flag_clear_n && !chip_disable;
    endsequence
    sequence s_err_clear;
        !error_flags_clear_n && !chip_disable;
    endsequence

    chk_oe_follows_cd: assert property (
        !$past(rst) |-> rx_holding_data_oe == !$past(chip_disable))
        else $error("holding enable not following chip disable");
    chk_rx_clear_takes: assert property (
        s_rx_clear |=> !char_received_flag)
        else $error("received flag survived its clear");
    chk_err_clear_takes: assert property (
        s_err_clear |=> !parity_error_flag && !overrun_flag)
        else $error("error flags survived their clear");
    chk_mclr_values: assert property (
        master_clear |=> rx_holding_data == 9'h1FF && !char_received_flag
        && !parity_error_flag && !overrun_flag && !match_flag)
        else $error("master clear values wrong");
    chk_upper_bits_low: assert property (
        $changed(rx_holding_data) && rx_holding_data != 9'h1FF
        && $stable(len_q)
        |-> (rx_holding_data[7:0] >> ({2'b00, len_q} + 4'h5)) == 8'h00)
        else $error("unused upper data bits not low");
    chk_overrun_cause: assert property (
        $rose(overrun_flag) |-> $past(char_received_flag))
        else $error("overrun without pending character");
    chk_dr_kept_held: assert property (
        char_received_flag && !master_clear
        && (received_flag_clear_n || chip_disable) |=> char_received_flag)
        else $error("received flag dropped without clear");
    chk_pe_kept_sticky: assert property (
        parity_error_flag && !master_clear
        && (error_flags_clear_n || chip_disable) |=> parity_error_flag)
        else $error("parity error dropped without clear");
endmodule

bind sro_receiver sro_receiver_properties u_props (
    .ref_clk(ref_clk), .rst(rst), .master_clear(master_clear),
    .chip_disable(chip_disable), .char_len_select(char_len_select),
    .control_load(control_load), .error_flags_clear_n(error_flags_clear_n),
    .received_flag_clear_n(received_flag_clear_n),
    .rx_holding_data(rx_holding_data),
    .rx_holding_data_oe(rx_holding_data_oe),
    .char_received_flag(char_received_flag),
    .parity_error_flag(parity_error_flag), .overrun_flag(overrun_flag),
    .match_flag(match_flag)
);

`default_nettype wire

// ### verification/sro_link_model.sv
`timescale 1ns/100ps
`default_nettype none

module sro_link_model (
    // clock
    input wire logic ref_clk,
    // serial line
    output logic rx_clk_pin,
    output logic rx_data_pin
);
    initial begin
        rx_clk_pin = 1'b1;
        rx_data_pin = 1'b0;
    end
    // ----------------------------------------------------------------
    // frame sender
    // ----------------------------------------------------------------
    // lsb first, 16 cycles a bit, fall at bit middle; clock idles high
    task automatic send(input logic [8:0] bits, input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rx_data_pin <= bits[i];
            rx_clk_pin <= 1'b1;
            repeat (8) @(posedge ref_clk);
            rx_clk_pin <= 1'b0;
            repeat (8) @(posedge ref_clk);
        end
        rx_clk_pin <= 1'b1;
        // released line must not keep the last bit
        rx_data_pin <= ~bits[n-1];
    endtask
endmodule

`default_nettype wire

// ### verification/test_sro_receiver.sv
`timescale 1ns/100ps
`default_nettype none

module test_sro_receiver;
    logic ref_clk, rst, rx_clk_pin, rx_data_pin, sync_hunt_input;
    logic master_clear, chip_disable, parity_off, even_parity_select;
    logic control_load, match_load, error_flags_clear_n;
    logic received_flag_clear_n, rx_holding_data_oe, char_received_flag;
    logic parity_error_flag, overrun_flag, match_flag;
    logic [1:0] char_len_select;
    logic [7:0] match_char_in;
    logic [8:0] rx_holding_data;
    int num_errors = 0;
    int checked = 0;

    sro_receiver dut (
        .ref_clk(ref_clk), .rst(rst), .rx_clk_pin(rx_clk_pin),
        .rx_data_pin(rx_data_pin), .sync_hunt_input(sync_hunt_input),
        .master_clear(master_clear), .chip_disable(chip_disable),
        .parity_off(parity_off), .even_parity_select(even_parity_select),
        .char_len_select(char_len_select), .control_load(control_load),
        .match_char_in(match_char_in), .match_load(match_load),
        .error_flags_clear_n(error_flags_clear_n),
        .received_flag_clear_n(received_flag_clear_n),
        .rx_holding_data(rx_holding_data),
        .rx_holding_data_oe(rx_holding_data_oe),
        .char_received_flag(char_received_flag),
        .parity_error_flag(parity_error_flag), .overrun_flag(overrun_flag),
        .match_flag(match_flag)
    );
    sro_link_model lnk (
        .ref_clk(ref_clk), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
            num_errors++;
        end
    endtask
    function automatic logic [8:0] flags();
        return {5'h00, match_flag, overrun_flag, parity_error_flag,
            char_received_flag};
    endfunction
    // host presents settings with a load pulse
    task automatic configure(input logic po, ev, input logic [1:0] len);
        @(posedge ref_clk);
        parity_off <= po;
        even_parity_select <= ev;
        char_len_select <= len;
        control_load <= 1'b1;
        @(posedge ref_clk);
        control_load <= 1'b0;
    endtask
    task automatic clear_dr;
        @(posedge ref_clk);
        received_flag_clear_n <= 1'b0;
        @(posedge ref_clk);
        received_flag_clear_n <= 1'b1;
    endtask
    task automatic frame(input logic [8:0] bits, input int n,
        input logic [8:0] hold, fl);
        lnk.send(bits, n);
        tick(1);
        check(rx_holding_data, hold);
        check(flags(), fl);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sync_search;
        configure(1'b0, 1'b1, 2'h3);
        @(posedge ref_clk);
        match_char_in <= 8'h16;
        match_load <= 1'b1;
        @(posedge ref_clk);
        match_load <= 1'b0;
        sync_hunt_input <= 1'b1;
        tick(8);
        lnk.send(9'h116, 9);
        tick(1);
        check(flags(), 9'h008);
        check({1'b0, rx_holding_data[7:0]}, 9'h016);
    endtask
    task automatic sync_frames;
        frame(9'h0A5, 9, 9'h0A5, 9'h001);
        frame(9'h15A, 9, 9'h15A, 9'h007);
        frame(9'h116, 9, 9'h116, 9'h00F);
    endtask
    task automatic disabled_clears;
        @(posedge ref_clk);
        chip_disable <= 1'b1;
        error_flags_clear_n <= 1'b0;
        received_flag_clear_n <= 1'b0;
        tick(2);
        check({8'h00, rx_holding_data_oe}, 9'h000);
        check(flags(), 9'h00F);
        @(posedge ref_clk);
        chip_disable <= 1'b0;
        received_flag_clear_n <= 1'b1;
        tick(2);
        check(flags(), 9'h009);
        check({8'h00, rx_holding_data_oe}, 9'h001);
        @(posedge ref_clk);
        error_flags_clear_n <= 1'b1;
        clear_dr();
        tick(1);
        check(flags(), 9'h008);
    endtask
    task automatic length_parity;
        configure(1'b0, 1'b0, 2'h0);
        frame(9'h015, 6, 9'h015, 9'h001);
        clear_dr();
        configure(1'b1, 1'b0, 2'h3);
        // a load while disabled must leave 8 bits, no parity in force
        @(posedge ref_clk);
        chip_disable <= 1'b1;
        configure(1'b0, 1'b0, 2'h0);
        @(posedge ref_clk);
        chip_disable <= 1'b0;
        frame(9'h0C3, 8, 9'h0C3, 9'h001);
    endtask
    task automatic master_reset;
        @(posedge ref_clk);
        master_clear <= 1'b1;
        @(posedge ref_clk);
        master_clear <= 1'b0;
        tick(1);
        check(rx_holding_data, 9'h1FF);
        check(flags(), 9'h000);
    endtask
    task automatic hunt_drop;
        @(posedge ref_clk);
        sync_hunt_input <= 1'b0;
        tick(8);
        // leaving sync from the synced state: no transfer, so no overrun
        frame(9'h03C, 8, 9'h03C, 9'h001);
    endtask

    task print_verdict;
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        sync_hunt_input = 1'b0;
        master_clear = 1'b0;
        chip_disable = 1'b0;
        parity_off = 1'b1;
        even_parity_select = 1'b0;
        char_len_select = 2'h3;
        control_load = 1'b0;
        match_char_in = 8'h00;
        match_load = 1'b0;
        error_flags_clear_n = 1'b1;
        received_flag_clear_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        tick(2);
        check(rx_holding_data, 9'h1FF);
        check(flags(), 9'h000);
        sync_search();
        sync_frames();
        disabled_clears();
        length_parity();
        hunt_drop();
        master_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
